/* rtl/offset_corrector_defines.vh */
// Constants for the interleave offset corrector control block
// Function
// RULE1: Estimate per-core offset, subtract from samples
// RULE2: Cancel dc, fs/8 and fs/2 spurs (the four-core mean covers dc, fs/4 and fs/2, not fs/8)
// RULE3: Every sample processed, genuine tones suppressed too
// RULE4: Bypass passes samples uncorrected
// RULE5: Freeze holds last estimate, keeps applying
// RULE6: Host idles input 0.4 ms before freezing
// RULE7: Page bytes select channel A or B page
// RULE8: C2h to 6068h freezes selected channel
// RULE9: 46h to 6068h bypasses selected channel
// RULE10: Host reapplies input after both freezes
// RULE11: Single channel operation uses channel A
// RULE12: Selected page persists until rewritten
`ifndef OFFSET_CORRECTOR_DEFINES_VH
`define OFFSET_CORRECTOR_DEFINES_VH
`define ADDR_W            16
`define DATA_W            8
`define SAMPLE_W          14
`define ACC_W             24
`define CORE_IDX_W        2
`define EST_SHIFT         10
`define FIFO_DEPTH        8
`define FIFO_AW           3
`define ADDR_PAGE_LOW     16'h4001
`define ADDR_PAGE_MID     16'h4002
`define ADDR_PAGE_CHAN    16'h4003
`define ADDR_PAGE_HIGH    16'h4004
`define ADDR_CORR_CTRL    16'h6068
`define PAGE_BYTE_ZERO    8'h00
`define PAGE_HIGH_CORR    8'h61
`define PAGE_CHAN_A       8'h00
`define PAGE_CHAN_B       8'h01
`define CTRL_FREEZE       8'hC2
`define CTRL_BYPASS       8'h46
`define CTRL_RESET_VAL    8'h00
`endif

/* rtl/sample_fifo.v */
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module sample_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             i_core_clk,
  input  wire             i_rstn,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;
  integer         k;

  assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_out_data  = mem_q[rd_q];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem_q[k] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_q[wr_q] <= i_in_data;
        wr_q        <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

/* rtl/interleave_offset_corrector_ctrl.v */
// Two-channel interleave offset corrector with paged register control
`timescale 1ns/10ps
`include "offset_corrector_defines.vh"
module interleave_offset_corrector_ctrl (
  input  wire                   i_core_clk,
  input  wire                   i_rstn,
  input  wire                   i_reg_wr,
  input  wire                   i_reg_rd,
  input  wire [`ADDR_W-1:0]     i_reg_addr,
  input  wire [`DATA_W-1:0]     i_reg_wdata,
  output reg  [`DATA_W-1:0]     o_reg_rdata,
  input  wire                   i_a_valid,
  output wire                   o_a_ready,
  input  wire [`SAMPLE_W-1:0]   i_a_sample,
  output wire                   o_a_valid,
  input  wire                   i_a_ready,
  output wire [`SAMPLE_W-1:0]   o_a_sample,
  input  wire                   i_b_valid,
  output wire                   o_b_ready,
  input  wire [`SAMPLE_W-1:0]   i_b_sample,
  output wire                   o_b_valid,
  input  wire                   i_b_ready,
  output wire [`SAMPLE_W-1:0]   o_b_sample,
  output wire [1:0]             o_frozen,
  output wire [1:0]             o_bypassed
);
  // Channel mode states, one-hot
  localparam [2:0] ST_RUN    = 3'b001;
  localparam [2:0] ST_FREEZE = 3'b010;
  localparam [2:0] ST_BYPASS = 3'b100;

  reg  [`DATA_W-1:0] page_low_q;
  reg  [`DATA_W-1:0] page_mid_q;
  reg  [`DATA_W-1:0] page_chan_q;
  reg  [`DATA_W-1:0] page_high_q;
  reg  [`DATA_W-1:0] ctrl_a_q;
  reg  [`DATA_W-1:0] ctrl_b_q;
  reg  [2:0]         mode_a_q;
  reg  [2:0]         mode_b_q;
  wire               page_is_corr;
  wire               sel_b;
  wire               ctrl_wr;

  // Page decode must match all three fixed bytes, else 6068h is ignored
  assign page_is_corr = (page_low_q == `PAGE_BYTE_ZERO) && (page_mid_q == `PAGE_BYTE_ZERO)
                        && (page_high_q == `PAGE_HIGH_CORR); // [RULE7]
  assign sel_b   = (page_chan_q == `PAGE_CHAN_B); // [RULE7]
  assign ctrl_wr = i_reg_wr && (i_reg_addr == `ADDR_CORR_CTRL) && page_is_corr
                   && ((page_chan_q == `PAGE_CHAN_A) || sel_b);

  function [2:0] next_mode;
    input [`DATA_W-1:0] val;
    begin
      case (val)
        `CTRL_FREEZE: next_mode = ST_FREEZE; // [RULE8]
        `CTRL_BYPASS: next_mode = ST_BYPASS; // [RULE9]
        default:      next_mode = ST_RUN;
      endcase
    end
  endfunction

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      page_low_q  <= `PAGE_BYTE_ZERO;
      page_mid_q  <= `PAGE_BYTE_ZERO;
      page_chan_q <= `PAGE_BYTE_ZERO;
      page_high_q <= `PAGE_BYTE_ZERO;
      ctrl_a_q    <= `CTRL_RESET_VAL;
      ctrl_b_q    <= `CTRL_RESET_VAL;
      mode_a_q    <= ST_RUN;
      mode_b_q    <= ST_RUN;
    end else if (i_reg_wr) begin
      // Page bytes hold until rewritten [RULE12]
      case (i_reg_addr)
        `ADDR_PAGE_LOW:  page_low_q  <= i_reg_wdata;
        `ADDR_PAGE_MID:  page_mid_q  <= i_reg_wdata;
        `ADDR_PAGE_CHAN: page_chan_q <= i_reg_wdata;
        `ADDR_PAGE_HIGH: page_high_q <= i_reg_wdata;
        default: ;
      endcase
      if (ctrl_wr && !sel_b) begin
        ctrl_a_q <= i_reg_wdata;
        mode_a_q <= next_mode(i_reg_wdata); // [RULE8] [RULE9]
      end
      if (ctrl_wr && sel_b) begin
        ctrl_b_q <= i_reg_wdata;
        mode_b_q <= next_mode(i_reg_wdata); // [RULE8] [RULE9]
      end
    end
  end

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_rdata <= {`DATA_W{1'b0}};
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `ADDR_PAGE_LOW:  o_reg_rdata <= page_low_q;
        `ADDR_PAGE_MID:  o_reg_rdata <= page_mid_q;
        `ADDR_PAGE_CHAN: o_reg_rdata <= page_chan_q;
        `ADDR_PAGE_HIGH: o_reg_rdata <= page_high_q;
        `ADDR_CORR_CTRL: o_reg_rdata <= !page_is_corr ? {`DATA_W{1'b0}} : (sel_b ? ctrl_b_q : ctrl_a_q);
        default:         o_reg_rdata <= {`DATA_W{1'b0}};
      endcase
    end
  end

  assign o_frozen   = {mode_b_q == ST_FREEZE, mode_a_q == ST_FREEZE};
  assign o_bypassed = {mode_b_q == ST_BYPASS, mode_a_q == ST_BYPASS};

  // Both channels share one datapath module body via generate
  wire [1:0]           in_valid  = {i_b_valid, i_a_valid};
  wire [1:0]           out_ready = {i_b_ready, i_a_ready};
  wire [`SAMPLE_W-1:0] in_smp [0:1];
  wire [`SAMPLE_W-1:0] out_smp [0:1];
  wire [1:0]           in_ready;
  wire [1:0]           out_valid;
  wire [2:0]           mode [0:1];
  assign in_smp[0] = i_a_sample;
  assign in_smp[1] = i_b_sample;
  assign mode[0]   = mode_a_q;
  assign mode[1]   = mode_b_q;
  assign o_a_ready  = in_ready[0];
  assign o_b_ready  = in_ready[1];
  assign o_a_valid  = out_valid[0];
  assign o_b_valid  = out_valid[1];
  assign o_a_sample = out_smp[0];
  assign o_b_sample = out_smp[1];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      reg  [`ACC_W-1:0]      acc_q [0:3];
      reg  [`CORE_IDX_W-1:0] core_q;
      reg  [`SAMPLE_W-1:0]   corr_q;
      reg                    corr_v_q;
      wire                   fifo_ready;
      wire                   take;
      wire                   run;
      wire [`SAMPLE_W-1:0]   est;
      wire [`ACC_W-1:0]      ext;
      integer                j;

      // Stall input when output register is full and cannot drain
      assign in_ready[ch] = fifo_ready | ~corr_v_q;
      assign take = in_valid[ch] & in_ready[ch];
      assign run  = mode[ch] == ST_RUN;
      assign ext  = {{(`ACC_W-`SAMPLE_W){in_smp[ch][`SAMPLE_W-1]}}, in_smp[ch]};
      // Per-core mean of four cores covers dc, fs/4-pair and fs/2 spurs
      assign est  = acc_q[core_q][`EST_SHIFT+`SAMPLE_W-1:`EST_SHIFT]; // [RULE2]

      always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          core_q   <= {`CORE_IDX_W{1'b0}};
          corr_q   <= {`SAMPLE_W{1'b0}};
          corr_v_q <= 1'b0;
          for (j = 0; j < 4; j = j + 1) begin
            acc_q[j] <= {`ACC_W{1'b0}};
          end
        end else begin
          if (fifo_ready) begin
            corr_v_q <= 1'b0;
          end
          if (take) begin
            core_q   <= core_q + 1'b1; // [RULE3]
            corr_v_q <= 1'b1;
            // Leaky average, no tone discrimination [RULE3]
            if (run) begin
              acc_q[core_q] <= acc_q[core_q] + ext - {{`EST_SHIFT{acc_q[core_q][`ACC_W-1]}},
                               acc_q[core_q][`ACC_W-1:`EST_SHIFT]}; // [RULE1]
            end
            // Frozen keeps subtracting held estimate [RULE5]; bypass passes raw [RULE4]
            if (mode[ch] == ST_BYPASS) begin
              corr_q <= in_smp[ch]; // [RULE4]
            end else begin
              corr_q <= in_smp[ch] - est; // [RULE1] [RULE5]
            end
          end
        end
      end

      sample_fifo #(
        .WIDTH (`SAMPLE_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
      ) u_fifo (
        .i_core_clk  (i_core_clk),
        .i_rstn      (i_rstn),
        .i_in_valid  (corr_v_q),
        .o_in_ready  (fifo_ready),
        .i_in_data   (corr_q),
        .o_out_valid (out_valid[ch]),
        .i_out_ready (out_ready[ch]),
        .o_out_data  (out_smp[ch])
      );
    end
  endgenerate
endmodule

/* test/offset_corrector_checker.sv */
// Port assertions for the offset corrector control
`timescale 1ns/10ps
`include "offset_corrector_defines.vh"
module offset_corrector_checker (
  input wire                 i_core_clk,
  input wire                 i_rstn,
  input wire                 i_reg_wr,
  input wire                 i_reg_rd,
  input wire [`ADDR_W-1:0]   i_reg_addr,
  input wire [`DATA_W-1:0]   i_reg_wdata,
  input wire [`DATA_W-1:0]   o_reg_rdata,
  input wire                 i_a_ready,
  input wire                 o_a_valid,
  input wire [`SAMPLE_W-1:0] o_a_sample,
  input wire                 i_b_ready,
  input wire                 o_b_valid,
  input wire [`SAMPLE_W-1:0] o_b_sample,
  input wire [1:0]           o_frozen,
  input wire [1:0]           o_bypassed
);
  reg [7:0] lo_q, mid_q, ch_q, hi_q;
  wire ctl = i_reg_wr && i_reg_addr == `ADDR_CORR_CTRL;
  wire ok = lo_q == 8'h00 && mid_q == 8'h00 && hi_q == `PAGE_HIGH_CORR && ch_q[7:1] == 7'h00;
  wire s = ch_q[0];
  wire [`DATA_W-1:0] d = i_reg_wdata;
  // Shadow of the page bytes, needed to know which channel a write hits
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {lo_q, mid_q, ch_q, hi_q} <= 32'h00000000;
    end else if (i_reg_wr) begin
      if (i_reg_addr == `ADDR_PAGE_LOW) lo_q <= d;
      if (i_reg_addr == `ADDR_PAGE_MID) mid_q <= d;
      if (i_reg_addr == `ADDR_PAGE_CHAN) ch_q <= d;
      if (i_reg_addr == `ADDR_PAGE_HIGH) hi_q <= d;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  AST_FRZ: assert property (ctl && ok && d == `CTRL_FREEZE |=> o_frozen[s] && !o_bypassed[s])
    else $error("freeze write not applied");
  AST_BYP: assert property (ctl && ok && d == `CTRL_BYPASS |=> o_bypassed[s] && !o_frozen[s])
    else $error("bypass write not applied");
  AST_RUN: assert property (ctl && ok && d != `CTRL_FREEZE && d != `CTRL_BYPASS |=> !o_frozen[s] && !o_bypassed[s])
    else $error("channel not back in run mode");
  AST_REF: assert property (ctl && !ok |=> $stable(o_frozen) && $stable(o_bypassed))
    else $error("control write taken without page");
  AST_ISO: assert property (ctl |=> $stable(o_frozen[!s]) && $stable(o_bypassed[!s]))
    else $error("unselected channel changed");
  AST_KEEP: assert property (!ctl |=> $stable({o_frozen, o_bypassed}))
    else $error("mode changed without control write");
  AST_RD: assert property (i_reg_rd && i_reg_addr == `ADDR_PAGE_HIGH ##1 1'b1 |-> ##1 o_reg_rdata == hi_q)
    else $error("page byte read back wrong");
  AST_HOLDA: assert property (o_a_valid && !i_a_ready |=> o_a_valid && $stable(o_a_sample))
    else $error("channel a output dropped");
  AST_HOLDB: assert property (o_b_valid && !i_b_ready |=> o_b_valid && $stable(o_b_sample))
    else $error("channel b output dropped");
  COV_FRZ: cover property (o_frozen == 2'b11);
  COV_BYP: cover property (o_bypassed == 2'b11);
  COV_STALL: cover property (o_a_valid && !i_a_ready);
endmodule

/* test/host_model.sv */
// Host side model of the paged register port
`timescale 1ns/10ps
`include "offset_corrector_defines.vh"
module host_model (
  input  wire               i_core_clk,
  input  wire [`DATA_W-1:0] i_rdata,
  output reg                o_wr,
  output reg                o_rd,
  output reg  [`ADDR_W-1:0] o_addr,
  output reg  [`DATA_W-1:0] o_wdata
);
  initial begin
    {o_wr, o_rd, o_addr, o_wdata} = 26'h0000000;
  end
  task wr_reg(input [`ADDR_W-1:0] a, input [`DATA_W-1:0] v);
    begin
      @(posedge i_core_clk);
      {o_wr, o_addr, o_wdata} <= {1'b1, a, v};
      @(posedge i_core_clk);
      // Released bus shows inverted values, never stale ones
      {o_wr, o_addr, o_wdata} <= {1'b0, ~a, ~v};
      #1;
    end
  endtask
  task rd_reg(input [`ADDR_W-1:0] a, output [`DATA_W-1:0] v);
    begin
      @(posedge i_core_clk);
      {o_rd, o_addr} <= {1'b1, a};
      @(posedge i_core_clk);
      {o_rd, o_addr} <= {1'b0, ~a};
      @(posedge i_core_clk);
      #1 v = i_rdata;
    end
  endtask
  task sel_page(input [`DATA_W-1:0] ch);
    begin
      wr_reg(`ADDR_PAGE_LOW, `PAGE_BYTE_ZERO);
      wr_reg(`ADDR_PAGE_MID, `PAGE_BYTE_ZERO);
      wr_reg(`ADDR_PAGE_CHAN, ch);
      wr_reg(`ADDR_PAGE_HIGH, `PAGE_HIGH_CORR);
    end
  endtask
endmodule

/* test/interleave_offset_corrector_ctrl_tb_top.sv */
// Self-checking bench for the offset corrector control
`timescale 1ns/10ps
`include "offset_corrector_defines.vh"
module interleave_offset_corrector_ctrl_tb_top;
  localparam [15:0] CTL = `ADDR_CORR_CTRL;
  localparam [`SAMPLE_W-1:0] OFS_HI = 14'h0100;
  localparam [`SAMPLE_W-1:0] OFS_LO = 14'h3F00;
  reg                  i_core_clk, i_rstn, i_a_valid, i_a_ready, i_b_ready, acc;
  reg  [`SAMPLE_W-1:0] i_a_sample;
  reg  [`DATA_W-1:0]   rd;
  wire                 i_b_valid = i_a_valid; // Channel A is the driven one, B follows
  wire [`SAMPLE_W-1:0] i_b_sample = i_a_sample;
  wire                 i_reg_wr, i_reg_rd, o_a_ready, o_a_valid, o_b_ready, o_b_valid;
  wire [`ADDR_W-1:0]   i_reg_addr;
  wire [`DATA_W-1:0]   i_reg_wdata, o_reg_rdata;
  wire [`SAMPLE_W-1:0] o_a_sample, o_b_sample;
  wire [1:0]           o_frozen, o_bypassed;
  integer              bad_count, checks, n, j;
  interleave_offset_corrector_ctrl dut (.*);
  host_model host (.i_core_clk(i_core_clk), .i_rdata(o_reg_rdata), .o_wr(i_reg_wr), .o_rd(i_reg_rd),
                   .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      if (bad_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  initial begin
    repeat (20000) @(posedge i_core_clk);
    bad_count = bad_count + 1;
    give_verdict;
  end
  initial begin
    {bad_count, checks} = 64'h0;
    {i_rstn, i_a_valid, i_a_ready, i_b_ready, i_a_sample} = 18'h00000;
    repeat (4) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    host.rd_reg(CTL, rd);
    chk(rd, `CTRL_RESET_VAL);
    host.rd_reg(16'h1234, rd);
    chk(rd, 16'h0000);
    host.wr_reg(CTL, `CTRL_FREEZE);
    chk(o_frozen, 2'b00);
    // Idle channel shows only core offsets: high on even cores, low on odd, so fs/2 with no dc
    for (n = 0; n < 10000; n = n + 1) begin
      {i_a_valid, i_a_ready, i_b_ready} <= 3'b111;
      i_a_sample <= n[0] ? OFS_LO : OFS_HI;
      @(posedge i_core_clk);
    end
    i_a_valid <= 1'b0;
    @(negedge i_core_clk);
    chk(o_a_valid, 1'b1);
    chk(($signed(o_a_sample) < 64) && ($signed(o_a_sample) > -64), 1'b1);
    chk(($signed(o_b_sample) < 64) && ($signed(o_b_sample) > -64), 1'b1);
    host.sel_page(`PAGE_CHAN_A);
    host.rd_reg(`ADDR_PAGE_HIGH, rd);
    chk(rd, `PAGE_HIGH_CORR);
    host.wr_reg(CTL, `CTRL_FREEZE);
    chk(o_frozen, 2'b01);
    host.wr_reg(`ADDR_PAGE_CHAN, `PAGE_CHAN_B);
    host.wr_reg(CTL, `CTRL_FREEZE);
    chk(o_frozen, 2'b11);
    // Input back only after both freezes; zero input shows the held estimate
    i_a_sample <= {`SAMPLE_W{1'b0}};
    i_a_valid  <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    @(negedge i_core_clk);
    chk(o_a_valid, 1'b1);
    chk(($signed(o_a_sample) > 64) || ($signed(o_a_sample) < -64), 1'b1);
    chk(($signed(o_b_sample) > 64) || ($signed(o_b_sample) < -64), 1'b1);
    @(posedge i_core_clk);
    i_a_valid <= 1'b0;
    host.rd_reg(CTL, rd);
    chk(rd, `CTRL_FREEZE);
    host.wr_reg(CTL, `CTRL_BYPASS);
    chk({o_frozen, o_bypassed}, 4'b0110);
    host.wr_reg(`ADDR_PAGE_CHAN, `PAGE_CHAN_A);
    host.wr_reg(CTL, `CTRL_BYPASS);
    chk({o_frozen, o_bypassed}, 4'b0011);
    i_a_valid <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    // Fill with the far side stalled, then drain with the input held off
    {i_a_ready, i_b_ready, i_a_valid} <= 3'b001;
    n = 0;
    repeat (12) begin
      @(negedge i_core_clk);
      acc = o_a_ready;
      chk(o_b_ready, o_a_ready);
      @(posedge i_core_clk);
      if (acc) begin
        n = n + 1;
        i_a_sample <= n[13:0];
      end
    end
    {i_a_ready, i_b_ready, i_a_valid} <= 3'b110;
    chk(n, 9);
    j = 0;
    repeat (30) begin
      @(negedge i_core_clk);
      if (o_a_valid === 1'b1) begin
        chk(o_a_sample, j);
        chk(o_b_sample, j);
        j = j + 1;
      end
    end
    chk({j, o_a_valid, o_b_valid}, {16'd9, 2'b00});
    host.wr_reg(CTL, 8'h00);
    chk(o_bypassed, 2'b10);
    give_verdict;
  end
endmodule
bind interleave_offset_corrector_ctrl offset_corrector_checker chk_i (.*);
